// File: ext_decoder_pkg.sv
// Constants for the extended instruction decoder.
// Assumes a 16-bit instruction word and 12-bit data addresses.
package ext_decoder_pkg;

  // ==========================================================
  // Encodings
  localparam logic [7:0]  OP_ADD_PTR      = 8'he8;
  localparam logic [7:0]  OP_SUB_PTR      = 8'he9;
  localparam logic [7:0]  OP_PUSH_LIT     = 8'hea;
  localparam logic [7:0]  OP_MOVE_IDX     = 8'heb;
  localparam logic [15:0] OP_CALL_WORKING_REGISTER    = 16'h0014;
  localparam logic [3:0]  OP_SECOND_WORD  = 4'hf;
  localparam logic [1:0]  SEL_FRAME       = 2'h3;
  localparam int          DEST_IDX_BIT    = 7;
  localparam int          ACCESS_BIT      = 8;
  localparam logic [7:0]  IDX_LIMIT       = 8'h60;

  // ==========================================================
  // Widths and reset values
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] PTR_RESET       = 12'h000;

  // ==========================================================
  // Operations presented to the core and decoder states
  typedef enum logic [3:0]
  {
    OPK_NONE     = 4'h0,
    OPK_PTR_ARITH = 4'h1,
    OPK_PUSH     = 4'h2,
    OPK_CALL_W   = 4'h3,
    OPK_MOVE     = 4'h4,
    OPK_RETURN   = 4'h5,
    OPK_STANDARD = 4'h6
  } op_kind_t;

  typedef enum logic [2:0]
  {
    ST_FETCH  = 3'b001,
    ST_RETURN = 3'b010,
    ST_SECOND = 3'b100
  } dec_state_t;

endpackage : ext_decoder_pkg

// File: extended_instruction_decoder.sv
// Decode and execute control for the extended instruction set.
// Assumes the fetch stage presents one word per cycle with instr_valid, and the
// register file performs the moves and stores that this block requests.
`timescale 1ns/100ps

module extended_instruction_decoder
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Configuration
  input  wire logic         extension_enable_config_bit,
  // Fetch stage
  input  wire logic         instr_valid,
  input  wire logic [15:0]  instr_word,
  input  wire logic [7:0]   working_register,
  // Pointer registers
  output logic [11:0]       indirect_pointer_register [3],
  // Core requests
  output ext_decoder_pkg::op_kind_t op_kind,
  output logic              status_write_en,
  output logic              mem_write_en,
  output logic [11:0]       mem_addr,
  output logic [11:0]       mem_src_addr,
  output logic [7:0]        mem_write_data,
  output logic              call_en,
  output logic [7:0]        call_target,
  output logic              return_en,
  output logic              stall,
  output logic              indexed_mode
);

  // ==========================================================
  // Decode helpers
  function automatic logic is_ext(input logic [15:0] w);
    is_ext = (w[15:8] == ext_decoder_pkg::OP_ADD_PTR) || (w[15:8] == ext_decoder_pkg::OP_SUB_PTR) ||
             (w[15:8] == ext_decoder_pkg::OP_PUSH_LIT) || (w[15:8] == ext_decoder_pkg::OP_MOVE_IDX) ||
             (w == ext_decoder_pkg::OP_CALL_WORKING_REGISTER);
  endfunction : is_ext

  function automatic logic [11:0] idx_addr(input logic [11:0] base, input logic [6:0] off);
    idx_addr = base + {5'h00, off};
  endfunction : idx_addr

  // ==========================================================
  // State
  ext_decoder_pkg::dec_state_t state;
  ext_decoder_pkg::dec_state_t next_state;
  logic [11:0] ptr [3];
  logic [11:0] next_ptr [3];
  logic        enabled;
  logic        next_enabled;
  logic [11:0] held_src;
  logic [11:0] next_held_src;
  logic        held_idx;
  logic        next_held_idx;
  ext_decoder_pkg::op_kind_t next_op_kind;
  logic        next_status_write_en;
  logic        next_mem_write_en;
  logic [11:0] next_mem_addr;
  logic [11:0] next_mem_src_addr;
  logic [7:0]  next_mem_write_data;
  logic        next_call_en;
  logic [7:0]  next_call_target;
  logic        next_return_en;
  logic        next_stall;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [1:0]  sel;
    logic [11:0] delta;
    logic [1:0]  tgt;
    sel                  = instr_word[7:6];
    delta                = {6'h00, instr_word[5:0]};
    // Select 11 names frame pointer two; only three pointers exist
    tgt                  = (sel == ext_decoder_pkg::SEL_FRAME) ? 2'h2 : sel;
    next_enabled         = enabled;
    next_state           = state;
    next_ptr             = ptr;
    next_held_src        = held_src;
    next_held_idx        = held_idx;
    next_op_kind         = ext_decoder_pkg::OPK_NONE;
    next_status_write_en = 1'b0;
    next_mem_write_en    = 1'b0;
    next_mem_addr        = mem_addr;
    next_mem_src_addr    = mem_src_addr;
    next_mem_write_data  = mem_write_data;
    next_call_en         = 1'b0;
    next_call_target     = call_target;
    next_return_en       = 1'b0;
    next_stall           = 1'b0;
    // Caught while fetch is idle and only ever turned on, so it cannot change in the middle of an instruction
    if (state == ext_decoder_pkg::ST_FETCH && !instr_valid && op_kind == ext_decoder_pkg::OPK_NONE
        && !enabled && !mem_write_en)
      next_enabled = extension_enable_config_bit;
    unique case (state)
      ext_decoder_pkg::ST_FETCH:
      begin
        if (instr_valid && enabled && is_ext(instr_word))
        begin
          if (instr_word == ext_decoder_pkg::OP_CALL_WORKING_REGISTER)
          begin
            next_op_kind     = ext_decoder_pkg::OPK_CALL_W;
            next_call_en     = 1'b1;
            next_call_target = working_register;
            next_stall       = 1'b1;
            next_state       = ext_decoder_pkg::ST_RETURN;
          end
          else if (instr_word[15:8] == ext_decoder_pkg::OP_PUSH_LIT)
          begin
            next_op_kind        = ext_decoder_pkg::OPK_PUSH;
            next_mem_write_en   = 1'b1;
            next_mem_addr       = ptr[2];
            next_mem_write_data = instr_word[7:0];
            next_ptr[2]         = ptr[2] - 12'h001;
          end
          else if (instr_word[15:8] == ext_decoder_pkg::OP_MOVE_IDX)
          begin
            next_held_src = idx_addr(ptr[2], instr_word[6:0]);
            next_held_idx = instr_word[ext_decoder_pkg::DEST_IDX_BIT];
            next_stall    = 1'b1;
            next_state    = ext_decoder_pkg::ST_SECOND;
          end
          else
          begin
            next_op_kind = ext_decoder_pkg::OPK_PTR_ARITH;
            if (instr_word[15:8] == ext_decoder_pkg::OP_ADD_PTR)
              next_ptr[tgt] = ptr[tgt] + delta;
            else
              next_ptr[tgt] = ptr[tgt] - delta;
            if (sel == ext_decoder_pkg::SEL_FRAME)
            begin
              next_stall = 1'b1;
              next_state = ext_decoder_pkg::ST_RETURN;
            end
          end
        end
        else if (instr_valid)
        begin
          next_op_kind         = ext_decoder_pkg::OPK_STANDARD;
          next_status_write_en = 1'b1;
          next_mem_addr        = {4'h0, instr_word[7:0]};
          if (enabled && !instr_word[ext_decoder_pkg::ACCESS_BIT]
              && instr_word[7:0] < ext_decoder_pkg::IDX_LIMIT)
            next_mem_addr = idx_addr(ptr[2], instr_word[6:0]);
        end
      end
      ext_decoder_pkg::ST_RETURN:
      begin
        // Second cycle of the frame-return forms and of the call
        next_op_kind   = ext_decoder_pkg::OPK_RETURN;
        next_return_en = (op_kind == ext_decoder_pkg::OPK_PTR_ARITH);
        next_state     = ext_decoder_pkg::ST_FETCH;
      end
      ext_decoder_pkg::ST_SECOND:
      begin
        if (instr_valid && instr_word[15:12] == ext_decoder_pkg::OP_SECOND_WORD)
        begin
          next_op_kind      = ext_decoder_pkg::OPK_MOVE;
          next_mem_write_en = 1'b1;
          next_mem_src_addr = held_src;
          if (held_idx)
            next_mem_addr = idx_addr(ptr[2], instr_word[6:0]);
          else
            next_mem_addr = instr_word[11:0];
          next_state = ext_decoder_pkg::ST_FETCH;
        end
        else
          next_stall = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state           <= ext_decoder_pkg::ST_FETCH;
      ptr             <= '{default: ext_decoder_pkg::PTR_RESET};
      enabled         <= 1'b0;
      held_src        <= ext_decoder_pkg::PTR_RESET;
      held_idx        <= 1'b0;
      op_kind         <= ext_decoder_pkg::OPK_NONE;
      status_write_en <= 1'b0;
      mem_write_en    <= 1'b0;
      mem_addr        <= ext_decoder_pkg::PTR_RESET;
      mem_src_addr    <= ext_decoder_pkg::PTR_RESET;
      mem_write_data  <= 8'h00;
      call_en         <= 1'b0;
      call_target     <= 8'h00;
      return_en       <= 1'b0;
      stall           <= 1'b0;
    end
    else
    begin
      enabled         <= next_enabled;
      state           <= next_state;
      ptr             <= next_ptr;
      held_src        <= next_held_src;
      held_idx        <= next_held_idx;
      op_kind         <= next_op_kind;
      status_write_en <= next_status_write_en;
      mem_write_en    <= next_mem_write_en;
      mem_addr        <= next_mem_addr;
      mem_src_addr    <= next_mem_src_addr;
      mem_write_data  <= next_mem_write_data;
      call_en         <= next_call_en;
      call_target     <= next_call_target;
      return_en       <= next_return_en;
      stall           <= next_stall;
    end
  end

  assign indirect_pointer_register = ptr;
  assign indexed_mode              = enabled;

endmodule : extended_instruction_decoder

// File: ext_decoder_chk_sva.sv
// Concurrent checks on the extended instruction decoder ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module ext_decoder_chk
(
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      reset,
  // Fetch side
  input wire logic                      extension_enable_config_bit,
  input wire logic                      instr_valid,
  input wire logic [15:0]               instr_word,
  input wire logic [7:0]                working_register,
  // Decoder outputs
  input wire logic [11:0]               indirect_pointer_register [3],
  input wire ext_decoder_pkg::op_kind_t op_kind,
  input wire logic                      status_write_en,
  input wire logic                      mem_write_en,
  input wire logic [11:0]               mem_addr,
  input wire logic [11:0]               mem_src_addr,
  input wire logic [7:0]                mem_write_data,
  input wire logic                      call_en,
  input wire logic [7:0]                call_target,
  input wire logic                      return_en,
  input wire logic                      stall,
  input wire logic                      indexed_mode
);
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = instr_valid && !stall && indexed_mode;
  chk_enable_sticky: assert property (indexed_mode |=> indexed_mode)
    else $error("extension enable dropped");
  chk_disabled_std: assert property (!indexed_mode && instr_valid && !stall |=> op_kind == ext_decoder_pkg::OPK_STANDARD)
    else $error("extended op ran while disabled");
  chk_ptr_one_cycle: assert property (take && instr_word[15:9] == 7'h74 && instr_word[7:6] != 2'b11
    |=> op_kind == ext_decoder_pkg::OPK_PTR_ARITH && !stall && !status_write_en)
    else $error("pointer arithmetic not single cycle");
  chk_frame_return: assert property (take && instr_word[15:9] == 7'h74 && instr_word[7:6] == 2'b11
    |=> stall ##1 return_en)
    else $error("frame form did not return");
  chk_call_target: assert property (take && instr_word == ext_decoder_pkg::OP_CALL_WORKING_REGISTER
    |=> call_en && call_target == $past(working_register) && !status_write_en)
    else $error("call target wrong");
  chk_move_write: assert property (stall && op_kind == ext_decoder_pkg::OPK_NONE && instr_valid
    && instr_word[15:12] == ext_decoder_pkg::OP_SECOND_WORD
    |=> mem_write_en)
    else $error("move did not write");
  chk_push_dec: assert property (op_kind == ext_decoder_pkg::OPK_PUSH
    |-> mem_write_en && indirect_pointer_register[2] == mem_addr - 12'h001)
    else $error("push pointer wrong");
  chk_push_data: assert property (take && instr_word[15:8] == ext_decoder_pkg::OP_PUSH_LIT
    |=> mem_write_data == $past(instr_word[7:0]))
    else $error("push data wrong");
endmodule : ext_decoder_chk
bind extended_instruction_decoder ext_decoder_chk u_ext_decoder_chk
(
  .ref_clk                     (ref_clk),
  .reset                       (reset),
  .extension_enable_config_bit (extension_enable_config_bit),
  .instr_valid                 (instr_valid),
  .instr_word                  (instr_word),
  .working_register            (working_register),
  .indirect_pointer_register   (indirect_pointer_register),
  .op_kind                     (op_kind),
  .status_write_en             (status_write_en),
  .mem_write_en                (mem_write_en),
  .mem_addr                    (mem_addr),
  .mem_src_addr                (mem_src_addr),
  .mem_write_data              (mem_write_data),
  .call_en                     (call_en),
  .call_target                 (call_target),
  .return_en                   (return_en),
  .stall                       (stall),
  .indexed_mode                (indexed_mode)
);

// File: extended_instruction_decoder_bench.sv
// Directed testbench for the extended instruction decoder.
// Assumes inputs change on the falling edge and outputs settle by then.
`timescale 1ns/100ps
module extended_instruction_decoder_bench;
  // ==========================================================
  // Signals
  logic                      ref_clk = 1'b0;
  logic                      reset = 1'b1;
  logic                      extension_enable_config_bit = 1'b0;
  logic                      instr_valid = 1'b0;
  logic [15:0]               instr_word = 16'h0000;
  logic [7:0]                working_register = 8'h00;
  logic [11:0]               indirect_pointer_register [3];
  ext_decoder_pkg::op_kind_t op_kind;
  logic                      status_write_en, mem_write_en, call_en, return_en, stall, indexed_mode;
  logic [11:0]               mem_addr, mem_src_addr;
  logic [7:0]                mem_write_data, call_target;
  int                        num_errors = 0;
  int                        comparisons = 0;
  extended_instruction_decoder u_extended_instruction_decoder
  (
    .ref_clk                     (ref_clk),
    .reset                       (reset),
    .extension_enable_config_bit (extension_enable_config_bit),
    .instr_valid                 (instr_valid),
    .instr_word                  (instr_word),
    .working_register            (working_register),
    .indirect_pointer_register   (indirect_pointer_register),
    .op_kind                     (op_kind),
    .status_write_en             (status_write_en),
    .mem_write_en                (mem_write_en),
    .mem_addr                    (mem_addr),
    .mem_src_addr                (mem_src_addr),
    .mem_write_data              (mem_write_data),
    .call_en                     (call_en),
    .call_target                 (call_target),
    .return_en                   (return_en),
    .stall                       (stall),
    .indexed_mode                (indexed_mode)
  );
  always #4 ref_clk = ~ref_clk;
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  // One idle cycle first keeps single-cycle ops apart
  task automatic send(input logic [15:0] w);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : send
  task automatic move(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] dst);
    // Valid stays high across both words, as the fetch stage presents them back to back
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word = w1;
    @(negedge ref_clk);
    check(stall, 1'b1);
    instr_word = w2;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    check(mem_write_en, 1'b1);
    check(mem_addr, dst);
    check(mem_src_addr, 12'h006);
  endtask : move
  task automatic frame(input logic [15:0] w, input logic [11:0] ptr);
    send(w);
    check(indirect_pointer_register[2], ptr);
    check(status_write_en, 1'b0);
    @(negedge ref_clk);
    check(return_en, 1'b1);
  endtask : frame
  // ==========================================================
  // Scenarios
  task automatic t_disabled;
    send(16'he845);
    check(op_kind, ext_decoder_pkg::OPK_STANDARD);
    check(indirect_pointer_register[1], 12'h000);
    check(mem_addr, 12'h045);
    extension_enable_config_bit = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(indexed_mode, 1'b1);
  endtask : t_disabled
  task automatic t_ptr;
    send(16'he845);
    check(op_kind, ext_decoder_pkg::OPK_PTR_ARITH);
    check(indirect_pointer_register[1], 12'h005);
    check({stall, status_write_en}, 2'b00);
    send(16'he942);
    check(indirect_pointer_register[1], 12'h003);
  endtask : t_ptr
  task automatic t_push;
    send(16'hea55);
    check({mem_write_en, mem_addr, mem_write_data}, {1'b1, 12'h000, 8'h55});
    check(indirect_pointer_register[2], 12'hfff);
  endtask : t_push
  task automatic t_call;
    working_register = 8'ha5;
    send(16'h0014);
    check({call_en, call_target, stall}, {1'b1, 8'ha5, 1'b1});
    check(status_write_en, 1'b0);
    @(negedge ref_clk);
    check(op_kind, ext_decoder_pkg::OPK_RETURN);
  endtask : t_call
  task automatic t_standard;
    send(16'h2410);
    check(op_kind, ext_decoder_pkg::OPK_STANDARD);
    check(mem_addr, 12'h011);
    check(status_write_en, 1'b1);
  endtask : t_standard
  // ==========================================================
  // Run control
  task automatic conclude;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    t_disabled();
    t_ptr();
    t_push();
    frame(16'he8c3, 12'h002);
    frame(16'he9c1, 12'h001);
    t_call();
    move(16'heb05, 16'hf123, 12'h123);
    move(16'heb85, 16'hf003, 12'h004);
    t_standard();
    conclude();
  end
  // Whole run is well under a hundred cycles
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
endmodule : extended_instruction_decoder_bench
